// [rtl/ffs_apb.sv]
/*
 * APB slave holding the control word and reading back status.
 * Assumes a standard APB master; zero-wait once out of reset.
 */
`timescale 1ns/1ps
`include "ffs_map.svh"
module ffs_apb
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	output ffs_pkg::ffs_ctrl_t       ctrl,
	input  wire ffs_pkg::ffs_status_t status
);
	logic [31:0]        next_prdata;
	logic               next_pslverr;
	ffs_pkg::ffs_ctrl_t next_ctrl;

	// decode at setup so the answer is a flop in the access phase
	always_comb
	begin
		next_prdata  = prdata;
		next_pslverr = pslverr;
		next_ctrl    = ctrl;
		if (psel && !penable)
		begin
			next_pslverr = 1'b0;
			if (paddr == `FFS_OFF_CTRL)
				next_prdata = {30'h0, ctrl};
			else if (paddr == `FFS_OFF_STATUS)
				next_prdata = {13'h0, status};
			else
			begin
				next_prdata  = 32'h0;
				next_pslverr = 1'b1;
			end
		end
		if (psel && penable && pready && pwrite && paddr == `FFS_OFF_CTRL)
		begin
			next_ctrl.sense_en = pwdata[`FFS_CTRL_SENSE];
			next_ctrl.ot_en    = pwdata[`FFS_CTRL_OT];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
			pready  <= 1'b0;
			ctrl    <= `FFS_CTRL_RST;
		end
		else
		begin
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
			pready  <= 1'b1;
			ctrl    <= next_ctrl;
		end
	end
endmodule

// [rtl/ffs_map.svh]
/*
 * Constants of the fan fault supervisor: register offsets, field positions,
 * reset values and PWM-tick / clock-cycle counts.
 * Assumes pclk at 250 MHz and one pwm_tick per PWM period.
 */
// Behaviour
// - shared flag is open-drain, active low
// - overheat asserts flag at threshold
// - overheat releases only below hysteresis level
// - 32 missing cycles start 3-cycle diagnostic
// - pulse in diagnostic resumes PWM, no fault
// - diagnostic fails: 32-cycle restart, pulse resumes
// - restart fails: fault state, flag low
// - fault: flag low, drive high, monitor
// - 16 pulses in 32 cycles ends fault
// - shutdown during fault releases flag, drive low
// - wake above release and autooff restarts
// - autooff during fault keeps flag, full drive
// - fault cleared then: auto-shutdown until hysteresis
// - pulses reset missing timer; 32 enters loop
// - blank sense input at drive turn-on
// - drop first pulse after turn-on in PWM
// - variants drop sensing or overheat
// - one flag for fault or overheat
// - 32-cycle full drive start-up period
// - shutdown: drive low, flag inactive
// - auto-shutdown: drive low, flag released
`ifndef FFS_MAP_SVH
`define FFS_MAP_SVH

`define FFS_OFF_CTRL       12'h000
`define FFS_OFF_STATUS     12'h004
`define FFS_CTRL_SENSE     0
`define FFS_CTRL_OT        1
`define FFS_CTRL_RST       2'h3

`define FFS_CLK_NS         4
`define FFS_BLANK_NS       2000
`define FFS_BLANK_CYC      ((`FFS_BLANK_NS + `FFS_CLK_NS - 1) / `FFS_CLK_NS)

`define FFS_STARTUP_TICKS  6'h20
`define FFS_DIAG_TICKS     6'h03
`define FFS_MISS_TICKS     6'h20
`define FFS_WIN_TICKS      6'h20
`define FFS_WIN_PULSES     6'h10

`endif

// [rtl/ffs_pkg.sv]
/*
 * Types of the fan fault supervisor: states, comparator bundle,
 * control and status words.
 * Assumes comparator bits already synchronous to pclk.
 */
package ffs_pkg;

	typedef enum logic [2:0]
	{
		FFS_ST_POWERUP,
		FFS_ST_RESTART,
		FFS_ST_DIAG,
		FFS_ST_RUN,
		FFS_ST_FAULT,
		FFS_ST_SHUTDOWN,
		FFS_ST_AUTOOFF
	} ffs_state_t;

	// each bit is one comparator on temp_level_input
	typedef struct packed
	{
		logic overheat_set;
		logic overheat_clear;
		logic below_shutdown;
		logic above_wake;
		logic above_autooff;
		logic above_autooff_hys;
	} ffs_cmp_t;

	typedef struct packed
	{
		logic ot_en;
		logic sense_en;
	} ffs_ctrl_t;

	typedef struct packed
	{
		logic [5:0] pulse_count;
		logic [5:0] tick_count;
		logic       drive;
		logic       flag;
		logic       overheat;
		logic       fault;
		logic [2:0] state;
	} ffs_status_t;

endpackage

// [rtl/ffs_sync.sv]
/*
 * Two-flop synchroniser with rising-edge detect for the sense detector.
 * Assumes the raw input may change at any time.
 */
`timescale 1ns/1ps
module ffs_sync
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic raw,
	output logic      rise
);
	logic s1;
	logic s2;
	logic s3;

	// edge taken from the second and third stage only
	assign rise = s2 & ~s3;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
		end
	end
endmodule

// [rtl/ffs_top.sv]
/*
 * Fan fault supervisor: start-up, missing-pulse, diagnostic, restart,
 * fault, shutdown and auto-shutdown sequencing; drive override and
 * the shared open-drain fault/overheat flag; APB control and status.
 * Assumes pwm_tick pulses once per PWM period, pwm_level is the duty
 * comparator, comparator bits are synchronous, sense_raw is asynchronous,
 * and a pull-up outside resolves the flag pin.
 */
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "ffs_map.svh"
module ffs_top
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             pwm_tick,
	input  wire logic             pwm_level,
	input  wire ffs_pkg::ffs_cmp_t temp_cmp,
	input  wire logic             sense_raw,
	output logic                  drive_out,
	output logic                  flag_out,
	output logic                  flag_oe
);
	localparam logic [8:0] BLANK_CYC = 9'(`FFS_BLANK_CYC);

	// ============================================================
	// state
	// ============================================================
	ffs_pkg::ffs_state_t  state;
	ffs_pkg::ffs_state_t  next_state;
	logic [5:0]           tick_cnt;
	logic [5:0]           next_tick_cnt;
	logic [5:0]           pulse_cnt;
	logic [5:0]           next_pulse_cnt;
	logic                 as_pending;
	logic                 next_as_pending;
	logic                 overheat;
	logic                 next_overheat;
	logic [8:0]           blank_cnt;
	logic [8:0]           next_blank_cnt;
	logic                 first_armed;
	logic                 next_first_armed;
	logic                 next_drive_out;
	logic                 next_flag_oe;
	logic                 sense_rise;
	logic                 pulse_ok;
	logic                 valid_pulse;
	logic                 fault;
	ffs_pkg::ffs_ctrl_t   ctrl;
	ffs_pkg::ffs_status_t status;

	function automatic logic [5:0] inc_sat(input logic [5:0] v);
		inc_sat = (v == 6'h3f) ? v : v + 6'h01;
	endfunction

	function automatic logic full_drive(input ffs_pkg::ffs_state_t s);
		full_drive = (s == ffs_pkg::FFS_ST_POWERUP) || (s == ffs_pkg::FFS_ST_RESTART) ||
			(s == ffs_pkg::FFS_ST_DIAG) || (s == ffs_pkg::FFS_ST_FAULT);
	endfunction

	// ============================================================
	// register slave and sense input
	// ============================================================
	ffs_apb ffs_apb_inst
	(
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.ctrl    (ctrl),
		.status  (status)
	);

	ffs_sync ffs_sync_inst
	(
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (sense_raw),
		.rise    (sense_rise)
	);

	always_comb
	begin
		status             = '0;
		status.state       = state;
		status.fault       = fault;
		status.overheat    = overheat;
		status.flag        = flag_oe;
		status.drive       = drive_out;
		status.tick_count  = tick_cnt;
		status.pulse_count = pulse_cnt;
	end

	// ============================================================
	// blanking and initial pulse blanker
	// ============================================================
	// pulses inside the blank window are switching noise of the drive
	assign pulse_ok = sense_rise && (blank_cnt == 9'h000) && ctrl.sense_en;
	// a locked rotor shows exactly one pulse per turn-on: drop it in PWM
	assign valid_pulse = pulse_ok && !(state == ffs_pkg::FFS_ST_RUN && first_armed);

	always_comb
	begin
		next_blank_cnt   = blank_cnt;
		next_first_armed = first_armed;
		if (next_drive_out && !drive_out)
		begin
			next_blank_cnt   = BLANK_CYC;
			next_first_armed = (next_state == ffs_pkg::FFS_ST_RUN);
		end
		else
		begin
			if (blank_cnt != 9'h000)
				next_blank_cnt = blank_cnt - 9'h001;
			if (pulse_ok || state != ffs_pkg::FFS_ST_RUN)
				next_first_armed = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blank_cnt   <= 9'h000;
			first_armed <= 1'b0;
		end
		else
		begin
			blank_cnt   <= next_blank_cnt;
			first_armed <= next_first_armed;
		end
	end

	// ============================================================
	// sequencer; every interval counts pwm_tick
	// ============================================================
	always_comb
	begin
		next_state      = state;
		next_tick_cnt   = tick_cnt;
		next_pulse_cnt  = pulse_cnt;
		next_as_pending = as_pending;
		if (temp_cmp.below_shutdown)
		begin
			next_state      = ffs_pkg::FFS_ST_SHUTDOWN;
			next_tick_cnt   = 6'h00;
			next_pulse_cnt  = 6'h00;
			next_as_pending = 1'b0;
		end
		else
		begin
			case (state)
				ffs_pkg::FFS_ST_POWERUP,
				ffs_pkg::FFS_ST_RESTART:
				begin
					if (valid_pulse)
					begin
						next_state    = ffs_pkg::FFS_ST_RUN;
						next_tick_cnt = 6'h00;
					end
					else if (pwm_tick)
					begin
						if (tick_cnt == `FFS_STARTUP_TICKS - 6'h01)
						begin
							next_tick_cnt  = 6'h00;
							next_pulse_cnt = 6'h00;
							if (!ctrl.sense_en)
								next_state = ffs_pkg::FFS_ST_RUN;
							else if (state == ffs_pkg::FFS_ST_POWERUP)
								next_state = ffs_pkg::FFS_ST_RESTART;
							else
								next_state = ffs_pkg::FFS_ST_FAULT;
						end
						else
							next_tick_cnt = inc_sat(tick_cnt);
					end
				end
				ffs_pkg::FFS_ST_DIAG:
				begin
					if (valid_pulse)
					begin
						next_state    = ffs_pkg::FFS_ST_RUN;
						next_tick_cnt = 6'h00;
					end
					else if (pwm_tick)
					begin
						if (tick_cnt == `FFS_DIAG_TICKS - 6'h01)
						begin
							next_state    = ffs_pkg::FFS_ST_RESTART;
							next_tick_cnt = 6'h00;
						end
						else
							next_tick_cnt = inc_sat(tick_cnt);
					end
				end
				ffs_pkg::FFS_ST_RUN:
				begin
					if (!temp_cmp.above_autooff)
					begin
						next_state    = ffs_pkg::FFS_ST_AUTOOFF;
						next_tick_cnt = 6'h00;
					end
					else if (valid_pulse || !ctrl.sense_en)
						next_tick_cnt = 6'h00;
					else if (pwm_tick)
					begin
						if (tick_cnt == `FFS_MISS_TICKS - 6'h01)
						begin
							next_state    = ffs_pkg::FFS_ST_DIAG;
							next_tick_cnt = 6'h00;
						end
						else
							next_tick_cnt = inc_sat(tick_cnt);
					end
				end
				ffs_pkg::FFS_ST_FAULT:
				begin
					if (!temp_cmp.above_autooff)
						next_as_pending = 1'b1;
					if (valid_pulse)
						next_pulse_cnt = inc_sat(pulse_cnt);
					if (!ctrl.sense_en)
					begin
						next_state      = ffs_pkg::FFS_ST_RUN;
						next_tick_cnt   = 6'h00;
						next_as_pending = 1'b0;
					end
					else if (pwm_tick)
					begin
						if (tick_cnt == `FFS_WIN_TICKS - 6'h01)
						begin
							// judge the window on its count, this cycle's pulse included
							if (next_pulse_cnt >= `FFS_WIN_PULSES)
							begin
								next_as_pending = 1'b0;
								if (as_pending || !temp_cmp.above_autooff)
									next_state = ffs_pkg::FFS_ST_AUTOOFF;
								else
									next_state = ffs_pkg::FFS_ST_RUN;
							end
							next_tick_cnt  = 6'h00;
							next_pulse_cnt = 6'h00;
						end
						else
							next_tick_cnt = inc_sat(tick_cnt);
					end
				end
				ffs_pkg::FFS_ST_SHUTDOWN:
				begin
					if (temp_cmp.above_wake && temp_cmp.above_autooff)
						next_state = ffs_pkg::FFS_ST_POWERUP;
				end
				ffs_pkg::FFS_ST_AUTOOFF:
				begin
					if (temp_cmp.above_autooff_hys)
						next_state = ffs_pkg::FFS_ST_POWERUP;
				end
				default:
				begin
					next_state    = ffs_pkg::FFS_ST_POWERUP;
					next_tick_cnt = 6'h00;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state      <= ffs_pkg::FFS_ST_POWERUP;
			tick_cnt   <= 6'h00;
			pulse_cnt  <= 6'h00;
			as_pending <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			tick_cnt   <= next_tick_cnt;
			pulse_cnt  <= next_pulse_cnt;
			as_pending <= next_as_pending;
		end
	end

	// ============================================================
	// overheat latch with hysteresis
	// ============================================================
	always_comb
	begin
		next_overheat = overheat;
		if (!ctrl.ot_en)
			next_overheat = 1'b0;
		else if (temp_cmp.overheat_set)
			next_overheat = 1'b1;
		else if (temp_cmp.overheat_clear)
			next_overheat = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			overheat <= 1'b0;
		else
			overheat <= next_overheat;
	end

	// ============================================================
	// pins
	// ============================================================
	assign fault = (state == ffs_pkg::FFS_ST_FAULT) && ctrl.sense_en;

	always_comb
	begin
		if (full_drive(next_state))
			next_drive_out = 1'b1;
		else if (next_state == ffs_pkg::FFS_ST_RUN)
			next_drive_out = pwm_level;
		else
			next_drive_out = 1'b0;
		// shutdown and auto-shutdown silence the flag even if hot
		if (next_state == ffs_pkg::FFS_ST_SHUTDOWN || next_state == ffs_pkg::FFS_ST_AUTOOFF)
			next_flag_oe = 1'b0;
		else
			next_flag_oe = ((next_state == ffs_pkg::FFS_ST_FAULT) && ctrl.sense_en) ||
				next_overheat;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			drive_out <= 1'b0;
			flag_out  <= 1'b0;
			flag_oe   <= 1'b0;
		end
		else
		begin
			drive_out <= next_drive_out;
			// open drain: only ever pulls low, the pull-up makes high
			flag_out  <= 1'b0;
			flag_oe   <= next_flag_oe;
		end
	end
endmodule

// [verif/ffs_chk.sv]
/* Assertions on the ports of ffs_top.
   Assumes one pclk domain and presetn async active low; bound below. */
`timescale 1ns/1ps
module ffs_chk
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire ffs_pkg::ffs_cmp_t temp_cmp,
	input wire logic              drive_out,
	input wire logic              flag_out,
	input wire logic              flag_oe
);
	// ==========
	// properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_flag_sink: assert property (flag_out == 1'b0)
		else $error("flag pin driven high");
	a_ready_up: assert property ($past(presetn) |-> pready)
		else $error("pready low out of reset");
	a_bad_addr: assert property (psel && penable && paddr > 12'h004 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_shdn_drive: assert property (temp_cmp.below_shutdown |=> !drive_out && !flag_oe)
		else $error("shutdown not honoured");
	a_hot_flag: assert property (temp_cmp.overheat_set |=> flag_oe)
		else $error("overheat not flagged");
	a_fault_full: assert property (flag_oe && temp_cmp.overheat_clear && $past(temp_cmp.overheat_clear) |-> drive_out)
		else $error("fault without full drive");
	a_wake_wait: assert property ($past(temp_cmp.below_shutdown) && !temp_cmp.above_wake |-> !drive_out)
		else $error("woke below release level");
	a_wake_go: assert property ($fell(temp_cmp.below_shutdown) && temp_cmp.above_wake && temp_cmp.above_autooff
		|=> drive_out)
		else $error("no start-up after wake");
endmodule
bind ffs_top ffs_chk ffs_chk_inst (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
	.temp_cmp, .drive_out, .flag_out, .flag_oe);

// [verif/ffs_fan.sv]
/* Fan with commutation detector, and the pull-up on the shared flag.
   Assumes drive_out high powers the fan. */
`timescale 1ns/1ps
module ffs_fan
(
	input  wire logic pclk,
	input  wire logic drive_out,
	input  wire logic spin,
	input  wire logic flag_out,
	input  wire logic flag_oe,
	output logic      sense_raw = 1'b0,
	output wire logic flag_pin
);
	// ==========
	// behaviour
	logic [5:0] cnt = 6'h0;
	// nobody sinking: pull-up wins
	assign flag_pin = flag_oe ? flag_out : 1'b1;
	// stalled or unpowered rotor gives no pulse
	always @(posedge pclk)
	begin
		cnt <= (cnt == 6'h27) ? 6'h0 : cnt + 6'h1;
		sense_raw <= drive_out && spin && cnt < 6'h2;
	end
endmodule

// [verif/test_ffs_top.sv]
/* Self-checking bench for ffs_top: APB tasks and fault sequences.
   Assumes pwm_tick every 100 pclk and ffs_fan as the fan. */
`timescale 1ns/1ps
module test_ffs_top;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [11:0]       paddr = 12'h0;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              pwm_tick = 1'b0;
	logic              pwm_level = 1'b1;
	ffs_pkg::ffs_cmp_t temp_cmp = 6'h17;
	logic              sense_raw;
	logic              drive_out;
	logic              flag_out;
	logic              flag_oe;
	logic              flag_pin;
	logic              spin = 1'b0;
	logic [6:0]        tcnt = 7'h0;
	logic [31:0]       rdata;
	logic              rerr;
	int                cyc = 0;
	int                error_cnt = 0;
	int                comparisons = 0;
	ffs_top ffs_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .pwm_tick, .pwm_level, .temp_cmp, .sense_raw, .drive_out, .flag_out, .flag_oe);
	ffs_fan ffs_fan_inst (.pclk, .drive_out, .spin, .flag_out, .flag_oe, .sense_raw, .flag_pin);
	// ==========
	// clock, period tick, timeout
	always #2 pclk = ~pclk;
	always @(posedge pclk)
	begin
		tcnt <= (tcnt == 7'h63) ? 7'h0 : tcnt + 7'h1;
		pwm_tick <= (tcnt == 7'h63);
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			error_cnt++;
			end_sim();
		end
	end
	// ==========
	// tasks
	task end_sim;
		if (error_cnt == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// state, overheat, flag, drive from status, plus the pin itself
	task stat(input logic [2:0] st, input logic ovh, input logic flg, input logic drv);
		apb(1'b0, 12'h004, 32'h0);
		chk({rdata[6:4], rdata[2:0]}, {drv, flg, ovh, st});
		chk(flag_pin, flg ? 32'h0 : 32'h1);
		chk(drive_out, drv);
	endtask
	task ticks(input int n);
		repeat (n) @(posedge pclk iff pwm_tick === 1'b1);
		repeat (4) @(posedge pclk);
	endtask
	// ==========
	// sequence
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk(rdata, 32'h3);
		apb(1'b0, 12'h008, 32'h0);
		chk(rerr, 32'h1);
		chk(rdata, 32'h0);
		stat(3'h0, 1'b0, 1'b0, 1'b1);
		ticks(33);
		stat(3'h1, 1'b0, 1'b0, 1'b1);
		ticks(32);
		stat(3'h4, 1'b0, 1'b1, 1'b1);
		spin <= 1'b1;
		ticks(66);
		stat(3'h3, 1'b0, 1'b0, 1'b1);
		ticks(40);
		stat(3'h3, 1'b0, 1'b0, 1'b1);
		pwm_level <= 1'b0;
		ticks(1);
		stat(3'h3, 1'b0, 1'b0, 1'b0);
		pwm_level <= 1'b1;
		ticks(8);
		stat(3'h3, 1'b0, 1'b0, 1'b1);
		spin <= 1'b0;
		ticks(33);
		stat(3'h2, 1'b0, 1'b0, 1'b1);
		spin <= 1'b1;
		ticks(2);
		stat(3'h3, 1'b0, 1'b0, 1'b1);
		spin <= 1'b0;
		ticks(36);
		stat(3'h1, 1'b0, 1'b0, 1'b1);
		spin <= 1'b1;
		ticks(2);
		stat(3'h3, 1'b0, 1'b0, 1'b1);
		temp_cmp <= 6'h27;
		ticks(1);
		stat(3'h3, 1'b1, 1'b1, 1'b1);
		temp_cmp <= 6'h07;
		ticks(1);
		stat(3'h3, 1'b1, 1'b1, 1'b1);
		temp_cmp <= 6'h17;
		ticks(1);
		stat(3'h3, 1'b0, 1'b0, 1'b1);
		temp_cmp <= 6'h18;
		ticks(1);
		stat(3'h5, 1'b0, 1'b0, 1'b0);
		temp_cmp <= 6'h17;
		ticks(1);
		stat(3'h0, 1'b0, 1'b0, 1'b1);
		ticks(34);
		stat(3'h3, 1'b0, 1'b0, 1'b1);
		temp_cmp <= 6'h14;
		ticks(1);
		stat(3'h6, 1'b0, 1'b0, 1'b0);
		temp_cmp <= 6'h16;
		ticks(2);
		stat(3'h6, 1'b0, 1'b0, 1'b0);
		temp_cmp <= 6'h17;
		apb(1'b1, 12'h000, 32'h2);
		spin <= 1'b0;
		ticks(70);
		stat(3'h3, 1'b0, 1'b0, 1'b1);
		apb(1'b0, 12'h000, 32'h0);
		chk(rdata, 32'h2);
		end_sim();
	end
endmodule
